// ==== hw/tfe_top.sv ====
/*
 * Timer flag and edge logic: counter clock edge selection, four
 * capture/compare flags with software and transfer-controller clears,
 * event status with mask and one interrupt line, Avalon-MM slave.
 * Assumes one 200 MHz clock, synchronous inputs and a synchronous
 * active-low reset. Capture/compare events arrive as one-cycle pulses.
 */
// Chosen here: the register offsets and the Avalon-MM slave port.
// Operation
// - Edge select only acts at divide-by-four or slower
// - Undivided clock counts every rising system edge
// - Controller activation clears flag D when permitted
// - Flag D clears on write 0 after read 1
// - Controller activation clears flag C when permitted
// - Flag C clears on write 0 after read 1
// - Controller activation clears flag B when permitted
// - Flag B write 0 unarmed leaves it set
// - Flag A clears under the same two conditions
`timescale 1ns/100ps
`include "tfe_defs.svh"

module tfe_top
   import tfe_pkg::*;
(
   input wire logic CORE_CLK,                  // System clock
   input wire logic NRST,                      // Sync reset, low
   input wire logic [`TFE_ADDR_W-1:0] AVS_ADDRESS, // Byte address
   input wire logic AVS_READ,                  // Read request
   input wire logic AVS_WRITE,                 // Write request
   input wire logic [31:0] AVS_WRITEDATA,      // Write data
   input wire logic [3:0] AVS_BYTEENABLE,      // Byte lanes
   output logic [31:0] AVS_READDATA,           // Read data
   output logic AVS_WAITREQUEST,               // Stall request
   input wire logic [3:0] CAPTURE_MATCH,       // Match events A..D
   input wire logic [3:0] DTC_ACT,             // Controller activated
   input wire logic DTC_DISABLE_SEL,           // Disable-select bit
   input wire logic DTC_COUNT_NZ,              // Counter not zero
   output logic [3:0] MATCH_IRQ,               // Channel requests
   output logic COUNT_TICK,                    // Counter enable
   output logic IRQ                            // Combined interrupt
);

   // Does a byte address hit a register offset
   function automatic logic reg_hit(
      input logic [`TFE_ADDR_W-1:0] addr,
      input logic [`TFE_ADDR_W-1:0] off
   );
      reg_hit = (addr == off);
   endfunction : reg_hit

   // Write merge for the low byte lane
   function automatic logic [7:0] lane0(
      input logic [7:0] old_v,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      lane0 = be[0] ? wd[7:0] : old_v;
   endfunction : lane0

   tfe_bus_t bus_r;                 // Bus answer phase
   tfe_bus_t bus_nxt;               // Next bus phase
   tfe_clkctl_t timer_clock_control_r; // Clock control register
   tfe_dtc_t dtc;                   // Controller request bundle
   logic [7:0] evstat_r;            // Sticky event status
   logic [7:0] evmask_r;            // Event mask
   logic [7:0] ev_set;              // Events this cycle
   logic [3:0] flags;               // Flag outputs from channels
   logic [3:0] dtc_clr;             // Qualified controller clears
   logic [3:0] dtc_done;            // Controller clears that acted
   logic [3:0] rd_one;              // Per-flag armed-read strobes
   logic [31:0] rdata_nxt;          // Read mux
   logic [31:0] rdata_r;            // Read data held for answer
   logic acc;                       // Request accepted this edge
   logic rd_acc;                    // Accepted read
   logic wr_acc;                    // Accepted write
   logic wr_ctl;                    // Write hits clock control
   logic wr_flags;                  // Write hits flag register
   logic wr_evstat;                 // Write hits event status
   logic wr_evmask;                 // Write hits event mask
   logic tick;                      // Count pulse from edge logic

   // Bundle controller inputs
   assign dtc.act = DTC_ACT;
   assign dtc.disable_select = DTC_DISABLE_SEL;
   assign dtc.count_nz = DTC_COUNT_NZ;

   // Bus phase: every request takes one stall cycle, then answers
   always_comb begin
      unique case (bus_r)
         TFE_BUS_IDLE: begin
            // Take the request and stall one cycle
            bus_nxt = (AVS_READ | AVS_WRITE) ? TFE_BUS_ANSWER
                                             : TFE_BUS_IDLE;
         end
         TFE_BUS_ANSWER: begin
            // Answer given, back to idle
            bus_nxt = TFE_BUS_IDLE;
         end
      endcase
   end

   // Bus phase register
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         bus_r <= TFE_BUS_IDLE;
      end else begin
         bus_r <= bus_nxt;
      end
   end

   // Waitrequest drops in the answer cycle only
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) &
                            (bus_r != TFE_BUS_ANSWER);
   assign acc = (bus_r == TFE_BUS_ANSWER) & (AVS_READ | AVS_WRITE);
   assign rd_acc = acc & AVS_READ;
   assign wr_acc = acc & AVS_WRITE;

   // Address decode of accepted writes
   assign wr_ctl = wr_acc & reg_hit(AVS_ADDRESS, `TFE_OFF_CLKCTL);
   assign wr_flags = wr_acc & reg_hit(AVS_ADDRESS, `TFE_OFF_FLAGS);
   assign wr_evstat = wr_acc & reg_hit(AVS_ADDRESS, `TFE_OFF_EVSTAT);
   assign wr_evmask = wr_acc & reg_hit(AVS_ADDRESS, `TFE_OFF_EVMASK);

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = '0;
      if (reg_hit(AVS_ADDRESS, `TFE_OFF_CLKCTL)) begin
         rdata_nxt[7:0] = timer_clock_control_r;
      end else if (reg_hit(AVS_ADDRESS, `TFE_OFF_FLAGS)) begin
         rdata_nxt[3:0] = flags;
      end else if (reg_hit(AVS_ADDRESS, `TFE_OFF_EVSTAT)) begin
         rdata_nxt[7:0] = evstat_r;
      end else if (reg_hit(AVS_ADDRESS, `TFE_OFF_EVMASK)) begin
         rdata_nxt[7:0] = evmask_r;
      end
   end

   // Snapshot taken in the stall cycle so the armed bits match
   // exactly what software is handed
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         rdata_r <= '0;
      end else if (bus_r == TFE_BUS_IDLE && AVS_READ) begin
         rdata_r <= rdata_nxt;
      end
   end
   assign AVS_READDATA = rdata_r;

   // A flag arms only if the handed-out value showed it as 1
   assign rd_one = (rd_acc && reg_hit(AVS_ADDRESS, `TFE_OFF_FLAGS))
                   ? rdata_r[3:0] : 4'h0;

   // Clock control register; unused bits stay zero
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         timer_clock_control_r <= `TFE_CLKCTL_RST;
      end else if (wr_ctl && AVS_BYTEENABLE[0]) begin
         timer_clock_control_r.prescale <=
            AVS_WRITEDATA[`TFE_PSC_MSB:`TFE_PSC_LSB];
         timer_clock_control_r.edge_select_lo <=
            AVS_WRITEDATA[`TFE_EDGE_LO_POS];
         timer_clock_control_r.edge_select_hi <=
            AVS_WRITEDATA[`TFE_EDGE_HI_POS];
      end
   end

   // Counter enable; edge field is ignored when undivided
   tfe_edge_sel u_edge (
      .clk(CORE_CLK),
      .nrst(NRST),
      .prescale(timer_clock_control_r.prescale),
      .edge_sel({timer_clock_control_r.edge_select_hi,
                 timer_clock_control_r.edge_select_lo}),
      .tick(tick)
   );
   assign COUNT_TICK = tick;

   // Controller clears only with disable-select 0 and count left
   assign dtc_clr = dtc.act &
                    {4{~dtc.disable_select & dtc.count_nz}};

   // Four channels A..D, bit index equals channel
   for (genvar ch = 0; ch < 4; ch++) begin : g_ch
      tfe_flag_ch u_flag (
         .clk(CORE_CLK),
         .nrst(NRST),
         .set_evt(CAPTURE_MATCH[ch]),
         .dtc_clr(dtc_clr[ch]),
         .rd_one(rd_one[ch]),
         .wr_acc(wr_flags),
         .wr_bit(AVS_WRITEDATA[ch] | ~AVS_BYTEENABLE[0]),
         .flag(flags[ch]),
         .dtc_done(dtc_done[ch])
      );
   end

   // Flags drive the channel requests while set
   assign MATCH_IRQ = flags;

   // Event sources: match events low, controller clears high
   assign ev_set = {dtc_done, CAPTURE_MATCH};

   // Sticky event status, write one clears, set wins
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         evstat_r <= `TFE_EVSTAT_RST;
      end else begin
         evstat_r <= ev_set |
            (evstat_r & ~((wr_evstat && AVS_BYTEENABLE[0])
                          ? AVS_WRITEDATA[7:0] : 8'h00));
      end
   end

   // Event mask; a 1 lets the event reach the line
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         evmask_r <= `TFE_EVMASK_RST;
      end else if (wr_evmask) begin
         evmask_r <= lane0(evmask_r, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   // Level interrupt, registered to keep the output glitch free
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(evstat_r & evmask_r);
      end
   end

endmodule : tfe_top

// ==== hw/tfe_defs.svh ====
/*
 * Offsets, field positions, reset values and divider figures for the
 * timer flag and edge logic. Assumes byte addressing on a 32-bit
 * Avalon-MM bus with one register per aligned word.
 */
`ifndef TFE_DEFS_SVH
`define TFE_DEFS_SVH

// Register byte offsets
`define TFE_ADDR_W 6
`define TFE_OFF_CLKCTL 6'h00
`define TFE_OFF_FLAGS 6'h04
`define TFE_OFF_EVSTAT 6'h08
`define TFE_OFF_EVMASK 6'h0c

// Clock control fields
`define TFE_PSC_LSB 0
`define TFE_PSC_MSB 1
`define TFE_EDGE_LO_POS 3
`define TFE_EDGE_HI_POS 4

// Prescale codes: system clock divided by 1, 4, 16, 64
`define TFE_PSC_DIV1 2'h0
`define TFE_PSC_DIV4 2'h1
`define TFE_PSC_DIV16 2'h2
`define TFE_PSC_DIV64 2'h3

// Divider counter bit that forms each divided clock
`define TFE_DIV_W 6
`define TFE_DIV4_BIT 1
`define TFE_DIV16_BIT 3
`define TFE_DIV64_BIT 5

// Edge select codes
`define TFE_EDGE_RISE 2'h0
`define TFE_EDGE_FALL 2'h1

// Reset values
`define TFE_CLKCTL_RST 8'h00
`define TFE_FLAGS_RST 4'h0
`define TFE_EVSTAT_RST 8'h00
`define TFE_EVMASK_RST 8'h00

`endif

// ==== hw/tfe_pkg.sv ====
/*
 * Types shared by the timer flag and edge logic.
 * Assumes tfe_defs.svh holds every number.
 */
package tfe_pkg;

   // Clock control register image
   typedef struct packed {
      logic [2:0] unused;       // Reads as zero
      logic edge_select_hi;     // Edge select, upper bit
      logic edge_select_lo;     // Edge select, lower bit
      logic prescale_hi;        // Unused prescale bit, kept zero
      logic [1:0] prescale;     // Input clock division
   } tfe_clkctl_t;

   // Requests from the data transfer controller
   typedef struct packed {
      logic [3:0] act;          // Activated by channel interrupt
      logic disable_select;     // Disable-select bit of its mode
      logic count_nz;           // Transfer counter not zero
   } tfe_dtc_t;

   // Bus answer phase
   typedef enum logic {TFE_BUS_IDLE, TFE_BUS_ANSWER} tfe_bus_t;

endpackage : tfe_pkg

// ==== hw/tfe_edge_sel.sv ====
/*
 * Counter clock enable: prescaler with edge selection.
 * Assumes one system clock; emits a one-cycle count pulse.
 */
`timescale 1ns/100ps
`include "tfe_defs.svh"

module tfe_edge_sel
   import tfe_pkg::*;
(
   input wire logic clk,             // System clock
   input wire logic nrst,            // Synchronous reset, low
   input wire logic [1:0] prescale,  // Division code
   input wire logic [1:0] edge_sel,  // Edge select field
   output logic tick                 // One-cycle count enable
);

   logic [`TFE_DIV_W-1:0] div_r;     // Free-running prescaler
   logic lvl;                        // Chosen divided clock level
   logic lvl_r;                      // Level one cycle earlier
   logic tick_nxt;                   // Next count pulse

   // Prescaler always runs so switching division is glitch free
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_r <= '0;
         lvl_r <= 1'b0;
      end else begin
         div_r <= div_r + 1'b1;
         lvl_r <= lvl;
      end
   end

   // Pick the divided clock
   always_comb begin
      unique case (prescale)
         `TFE_PSC_DIV4: lvl = div_r[`TFE_DIV4_BIT];
         `TFE_PSC_DIV16: lvl = div_r[`TFE_DIV16_BIT];
         `TFE_PSC_DIV64: lvl = div_r[`TFE_DIV64_BIT];
         default: lvl = 1'b0;
      endcase
   end

   // Edge choice applies only to divided clocks
   always_comb begin
      if (prescale == `TFE_PSC_DIV1) begin
         tick_nxt = 1'b1;
      end else if (edge_sel[1]) begin
         tick_nxt = lvl ^ lvl_r;
      end else if (edge_sel == `TFE_EDGE_FALL) begin
         tick_nxt = lvl_r & ~lvl;
      end else begin
         tick_nxt = lvl & ~lvl_r;
      end
   end

   // Registered pulse output
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= tick_nxt;
      end
   end

endmodule : tfe_edge_sel

// ==== hw/tfe_flag_ch.sv ====
/*
 * One compare/capture flag with its two clearing paths.
 * Assumes bus strobes are one-cycle pulses at the accepting edge.
 */
`timescale 1ns/100ps

module tfe_flag_ch (
   input wire logic clk,        // System clock
   input wire logic nrst,       // Synchronous reset, low
   input wire logic set_evt,    // Capture or compare match
   input wire logic dtc_clr,    // Qualified controller activation
   input wire logic rd_one,     // Accepted read saw this flag as 1
   input wire logic wr_acc,     // Accepted write to flag register
   input wire logic wr_bit,     // Written value of this bit
   output logic flag,           // Flag state
   output logic dtc_done        // Pulse: cleared by controller
);

   logic armed_r;               // A read of 1 came first
   logic sw_clr;                // Software clear this cycle

   assign sw_clr = wr_acc & ~wr_bit & armed_r;

   // Set wins over any clear in the same cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flag <= 1'b0;
      end else if (set_evt) begin
         flag <= 1'b1;
      end else if (dtc_clr | sw_clr) begin
         flag <= 1'b0;
      end
   end

   // Arming is spent by any write and lost once the flag drops
   always_ff @(posedge clk) begin
      if (!nrst) begin
         armed_r <= 1'b0;
      end else if (wr_acc) begin
         armed_r <= 1'b0;
      end else if (rd_one) begin
         armed_r <= 1'b1;
      end else if (!flag) begin
         armed_r <= 1'b0;
      end
   end

   // Report a controller clear that really took effect
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dtc_done <= 1'b0;
      end else begin
         dtc_done <= dtc_clr & flag & ~set_evt;
      end
   end

endmodule : tfe_flag_ch

// ==== verif/tfe_dtc_model.sv ====
/*
 * Behavioural transfer controller facing the channel requests.
 * Assumes the bench sets enable, disable-select, count and pace.
 */
`timescale 1ns/100ps

module tfe_dtc_model (
   input wire logic clk, // System clock
   input wire logic nrst, // Sync reset, low
   input wire logic [3:0] irq, // Channel requests from flags
   input wire logic en, // Answer requests at all
   input wire logic slow, // Answer three cycles late
   output logic [3:0] act // One-cycle activation pulses
);
   logic [3:0] prev_r; // Requests one cycle ago
   logic [11:0] pipe_r; // Pending activations, oldest on top

   // One activation per new request, like the real controller
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prev_r <= 4'h0;
         pipe_r <= 12'h000;
      end else begin
         prev_r <= irq;
         pipe_r <= {pipe_r[7:0], irq & ~prev_r & {4{en}}};
      end
   end

   // Prompt or slow answer; qualifiers come from the bench
   assign act = slow ? pipe_r[11:8] : pipe_r[3:0];
endmodule : tfe_dtc_model

// ==== verif/tfe_top_chk.sv ====
/*
 * Assertions on the ports of the flag and edge block.
 * Assumes one clock and a one-stall register bus.
 */
`timescale 1ns/100ps
`include "tfe_defs.svh"

module tfe_top_chk (
   input wire logic CORE_CLK, // Clock
   input wire logic NRST, // Reset, low
   input wire logic [`TFE_ADDR_W-1:0] AVS_ADDRESS, // Address
   input wire logic AVS_WRITE, // Write
   input wire logic AVS_READ, // Read
   input wire logic [31:0] AVS_WRITEDATA, // Write data
   input wire logic [3:0] AVS_BYTEENABLE, // Lanes
   input wire logic [31:0] AVS_READDATA, // Read data
   input wire logic AVS_WAITREQUEST, // Stall
   input wire logic [3:0] CAPTURE_MATCH, // Match events
   input wire logic [3:0] DTC_ACT, // Activations
   input wire logic DTC_DISABLE_SEL, // Disable-select
   input wire logic DTC_COUNT_NZ, // Count not zero
   input wire logic [3:0] MATCH_IRQ, // Flags
   input wire logic COUNT_TICK // Count enable
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   logic acc; // Bus cycle accepted
   logic fl_wr; // Accepted flag write
   logic fl_rd; // Accepted flag read
   logic ck_wr; // Accepted clock control write
   logic [3:0] armed_r; // Read as one, not yet written
   logic [3:0] clr_exp; // Flags this write must clear
   logic [3:0] keep_exp; // Flags this write must keep
   logic [1:0] psc_r; // Shadow prescale code
   logic [1:0] edge_r; // Shadow edge code
   logic [2:0] same_cnt; // Cycles since setup, saturates

   assign acc = !AVS_WAITREQUEST;
   assign fl_wr = acc && AVS_WRITE && AVS_ADDRESS == `TFE_OFF_FLAGS;
   assign fl_rd = acc && AVS_READ && AVS_ADDRESS == `TFE_OFF_FLAGS;
   assign ck_wr = acc && AVS_WRITE && AVS_ADDRESS == `TFE_OFF_CLKCTL
      && AVS_BYTEENABLE[0];
   // Lane 0 off counts as ones, so it clears nothing
   assign clr_exp = AVS_BYTEENABLE[0] ? armed_r & ~AVS_WRITEDATA[3:0]
      : 4'h0;
   assign keep_exp = MATCH_IRQ & ~clr_exp;

   // Arming: a read of one arms, any flag write disarms
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         armed_r <= 4'h0;
      end else if (fl_wr) begin
         armed_r <= 4'h0;
      end else if (fl_rd) begin
         armed_r <= (armed_r | AVS_READDATA[3:0]) & MATCH_IRQ;
      end else begin
         armed_r <= armed_r & MATCH_IRQ; // Cleared flag loses arming
      end
   end

   // Shadow of the clock setup; settling time hides tick latency
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         psc_r <= 2'h0;
         edge_r <= 2'h0;
         same_cnt <= 3'h0;
      end else if (ck_wr) begin
         psc_r <= AVS_WRITEDATA[1:0];
         edge_r <= AVS_WRITEDATA[4:3];
         same_cnt <= 3'h0;
      end else if (same_cnt != 3'h7) begin
         same_cnt <= same_cnt + 3'h1;
      end
   end

   a_match_sets_flag:
   assert property (CAPTURE_MATCH != 4'h0 |=> (MATCH_IRQ &
      $past(CAPTURE_MATCH)) == $past(CAPTURE_MATCH))
      else $error("match event did not set its flag");
   a_dtc_clears_a:
   assert property (DTC_ACT[0] && !DTC_DISABLE_SEL && DTC_COUNT_NZ
      && !CAPTURE_MATCH[0] |=> !MATCH_IRQ[0])
      else $error("controller did not clear flag a");
   a_dtc_clears_b:
   assert property (DTC_ACT[1] && !DTC_DISABLE_SEL && DTC_COUNT_NZ
      && !CAPTURE_MATCH[1] |=> !MATCH_IRQ[1])
      else $error("controller did not clear flag b");
   a_dtc_clears_c:
   assert property (DTC_ACT[2] && !DTC_DISABLE_SEL && DTC_COUNT_NZ
      && !CAPTURE_MATCH[2] |=> !MATCH_IRQ[2])
      else $error("controller did not clear flag c");
   a_dtc_clears_d:
   assert property (DTC_ACT[3] && !DTC_DISABLE_SEL && DTC_COUNT_NZ
      && !CAPTURE_MATCH[3] |=> !MATCH_IRQ[3])
      else $error("controller did not clear flag d");
   a_dtc_blocked_keeps:
   assert property (DTC_ACT != 4'h0 && (DTC_DISABLE_SEL || !DTC_COUNT_NZ)
      && !fl_wr |=> (MATCH_IRQ & $past(MATCH_IRQ)) == $past(MATCH_IRQ))
      else $error("blocked activation cleared a flag");
   a_armed_write_clears:
   assert property (fl_wr && CAPTURE_MATCH == 4'h0 |=>
      (MATCH_IRQ & $past(clr_exp)) == 4'h0)
      else $error("armed write of zero left a flag set");
   a_unarmed_write_keeps:
   assert property (fl_wr && DTC_ACT == 4'h0 |=>
      (MATCH_IRQ & $past(keep_exp)) == $past(keep_exp))
      else $error("unarmed write changed a flag");
   a_div1_every_cycle:
   assert property (psc_r == `TFE_PSC_DIV1 && same_cnt == 3'h7 |->
      COUNT_TICK) else $error("undivided clock missed a count");
   a_div4_both_edges:
   assert property (psc_r == `TFE_PSC_DIV4 && edge_r[1] && same_cnt == 3'h7
      && COUNT_TICK |=> !COUNT_TICK ##1 COUNT_TICK)
      else $error("both-edge count not every second cycle");
   a_div4_one_edge:
   assert property (psc_r == `TFE_PSC_DIV4 && !edge_r[1]
      && same_cnt == 3'h7 && COUNT_TICK |=> !COUNT_TICK [*3] ##1 COUNT_TICK)
      else $error("single-edge count not every fourth cycle");
endmodule : tfe_top_chk

bind tfe_top tfe_top_chk u_chk (.CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_WRITE,
   .AVS_READ, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
   .AVS_WAITREQUEST, .CAPTURE_MATCH, .DTC_ACT, .DTC_DISABLE_SEL,
   .DTC_COUNT_NZ, .MATCH_IRQ, .COUNT_TICK);

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for the flag and edge block.
 * Assumes the transfer controller model and the bound checker.
 */
`timescale 1ns/100ps

module testbench;
   logic CORE_CLK, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
   logic COUNT_TICK, DTC_DISABLE_SEL, DTC_COUNT_NZ, en, slow;
   logic [5:0] AVS_ADDRESS; // Byte address
   logic [31:0] AVS_WRITEDATA, AVS_READDATA; // Bus data
   logic [3:0] AVS_BYTEENABLE, CAPTURE_MATCH, DTC_ACT, MATCH_IRQ;
   int bad_count, check_count, cyc;

   tfe_top u_dut (.CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
      .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
      .CAPTURE_MATCH, .DTC_ACT, .DTC_DISABLE_SEL, .DTC_COUNT_NZ,
      .MATCH_IRQ, .COUNT_TICK, .IRQ);
   tfe_dtc_model u_dtc (.clk(CORE_CLK), .nrst(NRST), .irq(MATCH_IRQ),
      .en(en), .slow(slow), .act(DTC_ACT));

   // 200 MHz clock
   always #2.5 CORE_CLK = ~CORE_CLK;

   // Hang guard, far above the 1300 or so cycles needed
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   task print_verdict;
      if (bad_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request held until the edge that sees no stall
   task bus_wr(input logic [5:0] a, input logic [7:0] d,
      input logic [3:0] be);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h000000, d};
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= 1'b1;
      do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
      AVS_WRITE <= 1'b0;
      @(posedge CORE_CLK);
   endtask : bus_wr

   task bus_rd(input logic [5:0] a, output logic [31:0] d);
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
      d = AVS_READDATA;
      AVS_READ <= 1'b0;
      @(posedge CORE_CLK);
   endtask : bus_rd

   task pulse(input int n);
      CAPTURE_MATCH <= 4'h1 << n;
      @(posedge CORE_CLK);
      CAPTURE_MATCH <= 4'h0;
      @(posedge CORE_CLK);
   endtask : pulse

   // Reset values, read-only bits, unmapped place
   task t_regs;
      logic [31:0] d;
      for (int i = 0; i < 5; i++) begin
         bus_rd(6'(i * 4), d);
         chk(d, 32'h0);
      end
      bus_wr(6'h10, 8'hff, 4'hf);
      bus_wr(6'h00, 8'h1f, 4'hf);
      bus_wr(6'h0c, 8'h5a, 4'hf);
      bus_rd(6'h10, d);
      chk(d, 32'h0);
      bus_rd(6'h00, d);
      chk(d, 32'h1b);
      bus_rd(6'h0c, d);
      chk(d, 32'h5a);
      bus_wr(6'h0c, 8'h00, 4'hf);
   endtask : t_regs

   // Software clear needs a read of one first, lane 0 on
   task t_soft;
      logic [31:0] d;
      for (int n = 0; n < 4; n++) begin
         pulse(n);
         bus_wr(6'h04, 8'h00, 4'hf);
         chk(MATCH_IRQ, 4'h1 << n);
         bus_rd(6'h04, d);
         chk(d, 32'h1 << n);
         bus_wr(6'h04, 8'h00, 4'he);
         chk(MATCH_IRQ, 4'h1 << n);
         bus_rd(6'h04, d);
         bus_wr(6'h04, ~(8'h01 << n), 4'hf);
         chk(MATCH_IRQ, 4'h0);
      end
   endtask : t_soft

   // Masked and unmasked events on the shared interrupt
   task t_irq;
      logic [31:0] d;
      bus_wr(6'h08, 8'hff, 4'hf); // Drop events left by earlier tasks
      bus_wr(6'h0c, 8'h04, 4'hf);
      pulse(1);
      @(posedge CORE_CLK);
      chk(IRQ, 1'b0);
      bus_rd(6'h08, d);
      chk(d, 32'h02);
      pulse(2);
      @(posedge CORE_CLK);
      chk({IRQ, MATCH_IRQ}, 5'h16);
      bus_wr(6'h08, 8'h04, 4'hf);
      @(posedge CORE_CLK);
      chk(IRQ, 1'b0);
      bus_wr(6'h08, 8'hff, 4'hf);
      bus_rd(6'h04, d);
      bus_wr(6'h04, 8'h00, 4'hf);
   endtask : t_irq

   // Controller clears only when permitted, prompt and slow
   task t_dtc;
      logic [31:0] d;
      en <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         for (int n = 0; n < 4; n++) begin
            DTC_DISABLE_SEL <= (c == 1);
            DTC_COUNT_NZ <= (c != 2);
            slow <= n[0];
            bus_wr(6'h08, 8'hff, 4'hf);
            pulse(n);
            repeat (5) @(posedge CORE_CLK);
            chk(MATCH_IRQ, c == 0 ? 4'h0 : 4'h1 << n);
            bus_rd(6'h08, d);
            chk(d, c == 0 ? 32'h11 << n : 32'h1 << n);
            bus_rd(6'h04, d); // Leftover flag cleared by software
            bus_wr(6'h04, 8'h00, 4'hf);
         end
      end
      en <= 1'b0;
   endtask : t_dtc

   // Count rate for every division and edge choice over 64 cycles
   task t_ticks;
      int got, exp;
      for (int p = 0; p < 4; p++) begin
         for (int e = 0; e < 3; e++) begin
            bus_wr(6'h00, 8'((e << 3) | p), 4'hf);
            repeat (8) @(posedge CORE_CLK);
            got = 0;
            repeat (64) begin
               @(posedge CORE_CLK);
               if (COUNT_TICK === 1'b1) got++;
            end
            exp = (p == 0) ? 64 : (64 >> (2 * p)) * ((e == 2) ? 2 : 1);
            chk(got, exp);
         end
      end
   endtask : t_ticks

   initial begin
      {CORE_CLK, NRST, AVS_READ, AVS_WRITE, en, slow} = 6'h00;
      {DTC_DISABLE_SEL, DTC_COUNT_NZ} = 2'h1;
      {AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE, CAPTURE_MATCH} = '0;
      repeat (6) @(posedge CORE_CLK);
      NRST <= 1'b1;
      @(posedge CORE_CLK);
      t_regs();
      t_soft();
      t_irq();
      t_dtc();
      t_ticks();
      print_verdict();
   end
endmodule : testbench
